// [verilog/usp_device_end.sv]
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "usp_link_map.svh"
module usp_device_end #(
   parameter int IDLE_CYCLES = `USP_IDLE_SUSPEND_US * `USP_CLK_MHZ,
   parameter int WAKE_CYCLES = `USP_WAKE_PULSE_US * `USP_CLK_MHZ
) (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              srst,
   // link pins
   usp_link_if.dev                link,
   // firmware register port
   input  wire usp_pkg::usp_byte_t regAddr,
   input  wire usp_pkg::usp_byte_t regWdata,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output usp_pkg::usp_byte_t     regRdata,
   // serial engine side
   input  wire logic              sieDpOut,
   input  wire logic              sieDmOut,
   input  wire logic              sieDrive,
   // chip control
   input  wire logic              lowVoltageResetOption,
   output logic                   usbIrq,
   output logic                   serialEngineClockOn,
   output logic                   deepSuspendCtrl,
   output logic                   deviceResetReq
);
   import usp_pkg::*;

   localparam int BUS_RESET_CYCLES = (`USP_BUS_RESET_NS * `USP_CLK_MHZ + 999) / 1000;

   generate
      if (IDLE_CYCLES < 2 || WAKE_CYCLES < 1 || IDLE_CYCLES >= 2**24 || WAKE_CYCLES >= 2**24)
      begin : bad_param
         $error("usp_device_end timing parameter out of range");
      end
   endgenerate

   usp_dev_state_t state;
   logic [1:0]     pinSync;
   logic           lineDp;
   logic           lineDm;
   logic           prevDp;
   logic           prevDm;
   logic           lineK;
   logic           lineSe0;
   logic           busMove;
   logic           usbMode;
   logic           ps2Mode;
   logic [23:0]    idleCnt;
   logic [23:0]    wakeCnt;
   logic [8:0]     se0Cnt;
   logic           busResetSeen;
   logic           wakeReq;
   logic           suspendFlag;
   logic           resumeFlag;
   logic           busResetFlag;
   logic           auxDataOut;
   logic           auxClockOut;
   logic           kbdMouseModeSelect;
   logic           serialBusModeSelect;
   logic           auxDataIn;
   logic           auxClockIn;

   usp_pin_sync #(
      .WIDTH   (2),
      .RST_VAL (2'h3)
   ) u_sync (
      .ref_clk (ref_clk),
      .srst    (srst),
      .pinIn   ({link.dpLevel, link.dmLevel}),
      .pinOut  (pinSync)
   );

   assign lineDp  = pinSync[1];
   assign lineDm  = pinSync[0];
   assign lineK   = lineDp & ~lineDm;
   assign lineSe0 = ~lineDp & ~lineDm;
   assign busMove = (lineDp != prevDp) | (lineDm != prevDm);
   assign usbMode = serialBusModeSelect & ~kbdMouseModeSelect;
   assign ps2Mode = kbdMouseModeSelect & ~serialBusModeSelect;
   // a line held low by our own output reads low anyway
   assign auxDataIn  = lineDm & auxDataOut;
   assign auxClockIn = lineDp & auxClockOut;
   assign wakeReq = regWr && regAddr == `USP_REG_LINK_STATUS && regWdata[`USP_BIT_REMOTE_WAKE];
   assign busResetSeen = usbMode && lineSe0 && se0Cnt == 9'(BUS_RESET_CYCLES - 1);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         prevDp <= 1'b1;
         prevDm <= 1'b1;
      end else begin
         prevDp <= lineDp;
         prevDm <= lineDm;
      end
   end

   // firmware writable controls
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         kbdMouseModeSelect  <= `USP_RST_SEL;
         serialBusModeSelect <= `USP_RST_SEL;
         auxDataOut          <= `USP_RST_AUX_OUT;
         auxClockOut         <= `USP_RST_AUX_OUT;
         serialEngineClockOn <= 1'b0;
         deepSuspendCtrl     <= 1'b0;
      end else if (regWr) begin
         if (regAddr == `USP_REG_LINK_STATUS) begin
            auxDataOut  <= regWdata[`USP_BIT_AUX_DOUT];
            auxClockOut <= regWdata[`USP_BIT_AUX_COUT];
         end else if (regAddr == `USP_REG_MODE) begin
            kbdMouseModeSelect  <= regWdata[`USP_BIT_SEL_PS2];
            serialBusModeSelect <= regWdata[`USP_BIT_SEL_USB];
         end else if (regAddr == `USP_REG_CLOCK) begin
            serialEngineClockOn <= regWdata[`USP_BIT_ENG_CLK_ON];
            deepSuspendCtrl     <= regWdata[`USP_BIT_DEEP_SUSP];
         end
      end
   end

   // bad combination resets the chip, so it is only flagged outward
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         deviceResetReq <= 1'b0;
      end else begin
         deviceResetReq <= deepSuspendCtrl & lowVoltageResetOption;
      end
   end

   // idle timer, held clear outside usb mode, in se0 or once suspended
   // se0 is reset or keepalive, so a long bus reset never reads as idle
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         idleCnt <= '0;
      end else if (!usbMode || busMove || lineSe0 || state != ST_ACTIVE) begin
         idleCnt <= '0;
      end else if (idleCnt != 24'(IDLE_CYCLES)) begin
         idleCnt <= idleCnt + 24'h000001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         se0Cnt <= '0;
      end else if (!usbMode || !lineSe0) begin
         se0Cnt <= '0;
      end else if (se0Cnt != 9'(BUS_RESET_CYCLES)) begin
         se0Cnt <= se0Cnt + 9'h001;
      end
   end

   // event flag: hardware set beats firmware clear
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         busResetFlag <= 1'b0;
      end else if (busResetSeen) begin
         busResetFlag <= 1'b1;
      end else if (regWr && regAddr == `USP_REG_LINK_STATUS && !regWdata[`USP_BIT_BUS_RESET]) begin
         busResetFlag <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wakeCnt <= '0;
      end else if (state == ST_WAKE) begin
         wakeCnt <= wakeCnt + 24'h000001;
      end else begin
         wakeCnt <= '0;
      end
   end

   // link state
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state       <= ST_ACTIVE;
         suspendFlag <= 1'b0;
         resumeFlag  <= 1'b0;
         usbIrq      <= 1'b0;
      end else begin
         usbIrq <= 1'b0;
         if (!usbMode || (busResetSeen && state != ST_ACTIVE)) begin
            // leaving usb mode or bus reset ends any suspend
            usbIrq      <= suspendFlag;
            state       <= ST_ACTIVE;
            suspendFlag <= 1'b0;
            resumeFlag  <= 1'b0;
         end else begin
            case (state)
               ST_ACTIVE: begin
                  if (idleCnt == 24'(IDLE_CYCLES)) begin
                     state       <= ST_SUSPEND;
                     suspendFlag <= 1'b1;
                     usbIrq      <= 1'b1;
                  end
               end
               ST_SUSPEND: begin
                  if (wakeReq) begin
                     state <= ST_WAKE;
                  end else if (lineK) begin
                     state      <= ST_RESUME;
                     resumeFlag <= 1'b1;
                     usbIrq     <= 1'b1;
                  end
               end
               ST_WAKE: begin
                  // after the pulse, wait for the host's resume
                  if (wakeCnt == 24'(WAKE_CYCLES - 1)) begin
                     state <= ST_SUSPEND;
                  end
               end
               ST_RESUME: begin
                  if (!lineK) begin
                     state      <= ST_EOP;
                     resumeFlag <= 1'b0;
                  end
               end
               ST_EOP: begin
                  if (!lineK && !lineSe0) begin
                     state       <= ST_ACTIVE;
                     suspendFlag <= 1'b0;
                     usbIrq      <= 1'b1;
                  end
               end
               default: begin
                  state <= ST_ACTIVE;
               end
            endcase
         end
      end
   end

   // pin drivers, enables active low
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         link.devDpOut <= 1'b0;
         link.devDmOut <= 1'b0;
         link.devDpOeN <= 1'b1;
         link.devDmOeN <= 1'b1;
      end else if (ps2Mode) begin
         link.devDpOut <= 1'b0;
         link.devDmOut <= 1'b0;
         link.devDpOeN <= auxClockOut;
         link.devDmOeN <= auxDataOut;
      end else if (usbMode && state == ST_WAKE) begin
         link.devDpOut <= 1'b1;
         link.devDmOut <= 1'b0;
         link.devDpOeN <= 1'b0;
         link.devDmOeN <= 1'b0;
      end else if (usbMode) begin
         link.devDpOut <= sieDpOut;
         link.devDmOut <= sieDmOut;
         link.devDpOeN <= ~sieDrive;
         link.devDmOeN <= ~sieDrive;
      end else begin
         link.devDpOut <= 1'b0;
         link.devDmOut <= 1'b0;
         link.devDpOeN <= 1'b1;
         link.devDmOeN <= 1'b1;
      end
   end

   // read data stand one cycle, zero otherwise
   always_ff @(posedge ref_clk) begin
      if (srst || !regRd) begin
         regRdata <= 8'h00;
      end else if (regAddr == `USP_REG_LINK_STATUS) begin
         regRdata <= 8'h00;
         regRdata[`USP_BIT_SUSPEND]   <= suspendFlag;
         regRdata[`USP_BIT_BUS_RESET] <= busResetFlag;
         regRdata[`USP_BIT_RESUME]    <= resumeFlag;
         regRdata[`USP_BIT_AUX_DIN]   <= auxDataIn;
         regRdata[`USP_BIT_AUX_CIN]   <= auxClockIn;
      end else if (regAddr == `USP_REG_MODE) begin
         regRdata <= 8'h00;
         regRdata[`USP_BIT_SEL_PS2] <= kbdMouseModeSelect;
         regRdata[`USP_BIT_SEL_USB] <= serialBusModeSelect;
      end else if (regAddr == `USP_REG_CLOCK) begin
         regRdata <= 8'h00;
         regRdata[`USP_BIT_ENG_CLK_ON] <= serialEngineClockOn;
         regRdata[`USP_BIT_DEEP_SUSP]  <= deepSuspendCtrl;
      end else begin
         regRdata <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// [pkg/usp_link_map.svh]
`ifndef USP_LINK_MAP_SVH
`define USP_LINK_MAP_SVH

// register offsets
`define USP_REG_LINK_STATUS 8'h1A
`define USP_REG_MODE        8'h1B
`define USP_REG_CLOCK       8'h1C

// link_status_ctrl_reg fields
`define USP_BIT_SUSPEND     0
`define USP_BIT_REMOTE_WAKE 1
`define USP_BIT_BUS_RESET   2
`define USP_BIT_RESUME      3
`define USP_BIT_AUX_DIN     4
`define USP_BIT_AUX_CIN     5
`define USP_BIT_AUX_DOUT    6
`define USP_BIT_AUX_COUT    7

// mode_endpoint_reg fields
`define USP_BIT_SEL_PS2     4
`define USP_BIT_SEL_USB     5

// clock_ctrl_reg fields
`define USP_BIT_ENG_CLK_ON  3
`define USP_BIT_DEEP_SUSP   4

// reset values
`define USP_RST_AUX_OUT     1'b1
`define USP_RST_SEL         1'b0

// timing
`define USP_CLK_MHZ         100
`define USP_IDLE_SUSPEND_US 3000
`define USP_WAKE_PULSE_US   10000
`define USP_BUS_RESET_NS    2500
`define USP_RESUME_US       20000
`define USP_HOST_RESET_US   10000
`define USP_KEEPALIVE_US    1000
`define USP_EOP_NS          1330

`endif

// [pkg/usp_pkg.sv]
`default_nettype none
package usp_pkg;
   typedef enum logic [2:0] {
      ST_ACTIVE,
      ST_SUSPEND,
      ST_WAKE,
      ST_RESUME,
      ST_EOP
   } usp_dev_state_t;

   typedef enum logic [2:0] {
      HS_ACTIVE,
      HS_KEEPALIVE,
      HS_QUIET,
      HS_RESUME,
      HS_EOP,
      HS_RESET
   } usp_host_state_t;

   typedef logic [7:0] usp_byte_t;
endpackage
`default_nettype wire

// [pkg/usp_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface usp_link_if;
   logic devDpOut;
   logic devDpOeN;
   logic devDmOut;
   logic devDmOeN;
   logic hostDpOut;
   logic hostDpOeN;
   logic hostDmOut;
   logic hostDmOeN;
   logic dpLevel;
   logic dmLevel;

   // wired-AND of active drivers, pull-up when nobody drives
   assign dpLevel = (devDpOeN | devDpOut) & (hostDpOeN | hostDpOut);
   assign dmLevel = (devDmOeN | devDmOut) & (hostDmOeN | hostDmOut);

   modport dev (
      output devDpOut, devDpOeN, devDmOut, devDmOeN,
      input  dpLevel, dmLevel
   );
   modport host (
      output hostDpOut, hostDpOeN, hostDmOut, hostDmOeN,
      input  dpLevel, dmLevel
   );
endinterface
`default_nettype wire

// [verilog/usp_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module usp_pin_sync #(
   parameter int         WIDTH   = 2,
   parameter logic [1:0] RST_VAL = 2'h3
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             srst,
   // pins and filtered result
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] pinOut
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   generate
      if (WIDTH != 2) begin : bad_width
         $error("usp_pin_sync serves two pins only");
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         stage1 <= RST_VAL;
         stage2 <= RST_VAL;
         stage3 <= RST_VAL;
      end else begin
         stage1 <= pinIn;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // change accepted only once stages two and three agree
   genvar i;
   for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            pinOut[i] <= RST_VAL[i];
         end else if (stage2[i] == stage3[i]) begin
            pinOut[i] <= stage2[i];
         end
      end
   end
endmodule
`default_nettype wire

// [verilog/usp_host_end.sv]
`timescale 1ns/1ps
`default_nettype none
`include "usp_link_map.svh"
module usp_host_end #(
   parameter int RESUME_CYCLES    = `USP_RESUME_US * `USP_CLK_MHZ,
   parameter int RESET_CYCLES     = `USP_HOST_RESET_US * `USP_CLK_MHZ,
   parameter int KEEPALIVE_CYCLES = `USP_KEEPALIVE_US * `USP_CLK_MHZ
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic srst,
   // link pins
   usp_link_if.host  link,
   // user commands
   input  wire logic usbMode,
   input  wire logic cmdSuspend,
   input  wire logic cmdResume,
   input  wire logic cmdReset,
   input  wire logic ps2ClockLow,
   input  wire logic ps2DataLow,
   // user status
   output logic      wakeSeen,
   output logic      busy,
   output logic      ps2ClockLevel,
   output logic      ps2DataLevel
);
   import usp_pkg::*;

   localparam int EOP_CYCLES = `USP_EOP_NS * `USP_CLK_MHZ / 1000;

   generate
      if (RESUME_CYCLES < 1 || RESET_CYCLES < 1 || KEEPALIVE_CYCLES < 1
          || RESUME_CYCLES >= 2**24 || RESET_CYCLES >= 2**24 || KEEPALIVE_CYCLES >= 2**24)
      begin : bad_param
         $error("usp_host_end timing parameter out of range");
      end
   endgenerate

   usp_host_state_t state;
   logic [1:0]      pinSync;
   logic [23:0]     cnt;
   logic            lineK;
   logic            expired;

   usp_pin_sync #(
      .WIDTH   (2),
      .RST_VAL (2'h3)
   ) u_sync (
      .ref_clk (ref_clk),
      .srst    (srst),
      .pinIn   ({link.dpLevel, link.dmLevel}),
      .pinOut  (pinSync)
   );

   assign lineK = pinSync[1] & ~pinSync[0];

   always_comb begin
      case (state)
         HS_ACTIVE:    expired = cnt == 24'(KEEPALIVE_CYCLES - 1);
         HS_KEEPALIVE: expired = cnt == 24'(EOP_CYCLES - 1);
         HS_EOP:       expired = cnt == 24'(EOP_CYCLES - 1);
         HS_RESUME:    expired = cnt == 24'(RESUME_CYCLES - 1);
         HS_RESET:     expired = cnt == 24'(RESET_CYCLES - 1);
         default:      expired = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state    <= HS_ACTIVE;
         cnt      <= '0;
         wakeSeen <= 1'b0;
      end else begin
         wakeSeen <= 1'b0;
         cnt      <= expired ? 24'h000000 : cnt + 24'h000001;
         if (!usbMode) begin
            state <= HS_QUIET;
            cnt   <= '0;
         end else if (cmdReset) begin
            state <= HS_RESET;
            cnt   <= '0;
         end else begin
            case (state)
               HS_ACTIVE: begin
                  if (cmdSuspend) begin
                     state <= HS_QUIET;
                  end else if (expired) begin
                     state <= HS_KEEPALIVE;
                  end
               end
               HS_KEEPALIVE: begin
                  if (expired) begin
                     state <= HS_ACTIVE;
                  end
               end
               HS_QUIET: begin
                  cnt <= '0;
                  // a wake pulse is answered with resume signalling
                  if (lineK || cmdResume) begin
                     wakeSeen <= lineK;
                     state    <= HS_RESUME;
                  end
               end
               HS_RESUME: begin
                  if (expired) begin
                     state <= HS_EOP;
                  end
               end
               HS_EOP, HS_RESET: begin
                  if (expired) begin
                     state <= HS_ACTIVE;
                  end
               end
               default: begin
                  state <= HS_ACTIVE;
               end
            endcase
         end
      end
   end

   // pin drivers, enables active low
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         link.hostDpOut <= 1'b0;
         link.hostDmOut <= 1'b1;
         link.hostDpOeN <= 1'b1;
         link.hostDmOeN <= 1'b1;
      end else if (!usbMode) begin
         // open-drain style: only ever pull low
         link.hostDpOut <= 1'b0;
         link.hostDmOut <= 1'b0;
         link.hostDpOeN <= ~ps2ClockLow;
         link.hostDmOeN <= ~ps2DataLow;
      end else begin
         link.hostDpOut <= state == HS_RESUME;
         link.hostDmOut <= state == HS_ACTIVE;
         link.hostDpOeN <= state == HS_QUIET;
         link.hostDmOeN <= state == HS_QUIET;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         busy          <= 1'b0;
         ps2ClockLevel <= 1'b1;
         ps2DataLevel  <= 1'b1;
      end else begin
         busy          <= state == HS_RESUME || state == HS_EOP || state == HS_RESET;
         ps2ClockLevel <= pinSync[1];
         ps2DataLevel  <= pinSync[0];
      end
   end
endmodule
`default_nettype wire

// [dv/usp_link_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module usp_link_monitor #(
   parameter int WAKE_CYCLES = 50
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // device drive
   input wire logic devDpOut,
   input wire logic devDpOeN,
   input wire logic devDmOut,
   input wire logic devDmOeN,
   // host drive
   input wire logic hostDpOut,
   input wire logic hostDpOeN,
   input wire logic hostDmOut,
   input wire logic hostDmOeN,
   // wire levels
   input wire logic dpLevel,
   input wire logic dmLevel
);
   int kRun;
   wire logic devK = !devDpOeN && !devDmOeN && devDpOut && !devDmOut;
   wire logic hostK = !hostDpOeN && !hostDmOeN && hostDpOut && !hostDmOut;
   wire logic hostSE0 = !hostDpOeN && !hostDmOeN && !hostDpOut && !hostDmOut;
   wire logic hostRel = hostDpOeN && hostDmOeN;
   // run length of device K, so long counts need no repetition
   always_ff @(posedge ref_clk) begin
      if (srst) kRun <= 0;
      else kRun <= devK ? kRun + 1 : 0;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   sequence answer_s; ##[1:20] hostK; endsequence
   sequence resume_s; hostK [*8]; endsequence
   rst_release_a: assert property ($fell(srst) |-> devDpOeN && devDmOeN)
      else $error("device drives pins after reset");
   wake_len_a: assert property (kRun <= WAKE_CYCLES + 1)
      else $error("wake pulse too long");
   wake_answer_a: assert property ($rose(devK) && hostRel |-> answer_s)
      else $error("host did not answer wake");
   wake_release_a: assert property ($fell(devK) && kRun >= 20 |-> devDpOeN && devDmOeN)
      else $error("device kept pins after wake");
   wake_line_a: assert property (devK && hostRel |-> dpLevel && !dmLevel)
      else $error("wake pulse not seen on the line");
   resume_hold_a: assert property ($rose(hostK) |-> resume_s)
      else $error("resume signalling too short");
   resume_end_a: assert property ($fell(hostK) |-> hostSE0)
      else $error("resume not closed by end of packet");
   dev_ps2_drive_a: assert property (devDpOeN != devDmOeN |-> (devDpOeN ? !devDmOut : !devDpOut))
      else $error("device ps2 line driven high");
   host_ps2_drive_a: assert property (hostDpOeN != hostDmOeN |-> (hostDpOeN ? !hostDmOut : !hostDpOut))
      else $error("host ps2 line driven high");
endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "usp_link_map.svh"
module tb;
   import usp_pkg::*;
   localparam int IDLE = 200;
   localparam usp_byte_t ST = `USP_REG_LINK_STATUS;
   localparam usp_byte_t MD = `USP_REG_MODE;
   localparam usp_byte_t CK = `USP_REG_CLOCK;
   logic        ref_clk = 0;
   logic        srst = 1;
   usp_byte_t   regAddr = 8'h00, regWdata = 8'h00, regRdata, d;
   logic        regWr = 0, regRd = 0, sieDp = 0, sieDm = 0, sieDrive = 0, lvr = 0;
   logic        usbIrq, engClk, deepSusp, resetReq, wakeSeen, busy, clkLevel, datLevel;
   logic        usbMode = 0, clkLow = 0, datLow = 0;
   logic [2:0]  cmd = 3'h0;
   logic [3:0]  v;
   logic [31:0] seed = 34759, r;
   int          err_count = 0, total_checks = 0, irqCount = 0, wakeCount = 0, n, w, cyc;
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (usbIrq === 1'b1) irqCount++;
      if (wakeSeen === 1'b1) wakeCount++;
   end
   usp_link_if link ();
   usp_device_end #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(50)) usp_device_end_i (
      .ref_clk(ref_clk), .srst(srst), .link(link), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sieDpOut(sieDp), .sieDmOut(sieDm),
      .sieDrive(sieDrive), .lowVoltageResetOption(lvr), .usbIrq(usbIrq),
      .serialEngineClockOn(engClk), .deepSuspendCtrl(deepSusp), .deviceResetReq(resetReq));
   usp_host_end #(.RESUME_CYCLES(100), .RESET_CYCLES(300), .KEEPALIVE_CYCLES(400)) usp_host_end_i (
      .ref_clk(ref_clk), .srst(srst), .link(link), .usbMode(usbMode), .cmdSuspend(cmd[0]),
      .cmdResume(cmd[1]), .cmdReset(cmd[2]), .ps2ClockLow(clkLow), .ps2DataLow(datLow),
      .wakeSeen(wakeSeen), .busy(busy), .ps2ClockLevel(clkLevel), .ps2DataLevel(datLevel));
   usp_link_monitor #(.WAKE_CYCLES(50)) usp_link_monitor_i (
      .ref_clk(ref_clk), .srst(srst), .devDpOut(link.devDpOut), .devDpOeN(link.devDpOeN),
      .devDmOut(link.devDmOut), .devDmOeN(link.devDmOeN), .hostDpOut(link.hostDpOut),
      .hostDpOeN(link.hostDpOeN), .hostDmOut(link.hostDmOut), .hostDmOeN(link.hostDmOeN),
      .dpLevel(link.dpLevel), .dmLevel(link.dmLevel));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // {clk out, data out, host clk low, host data low}: a line reads high only if nobody pulls
   function automatic logic [1:0] aux_exp(logic [3:0] x);
      return {x[3] & ~x[1], x[2] & ~x[0]};
   endfunction
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input usp_byte_t a, input usp_byte_t x);
      @(posedge ref_clk);
      regAddr <= a;
      regWdata <= x;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask
   task rd(input usp_byte_t a, output usp_byte_t x);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      @(posedge ref_clk);
      x = regRdata;
   endtask
   task go(input logic [2:0] c);
      @(posedge ref_clk);
      cmd <= c;
      @(posedge ref_clk);
      cmd <= 3'h0;
   endtask
   task host_idle();
      repeat (3) @(posedge ref_clk);
      for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge ref_clk);
   endtask
   task wait_irq(input int m);
      for (int k = 0; k < 2000 && irqCount < m; k++) @(posedge ref_clk);
      repeat (3) @(posedge ref_clk);
   endtask
   // timed from the suspend order; filter latency allowed on top of the idle count
   task suspend_timed();
      n = irqCount;
      go(3'h1);
      for (cyc = 0; cyc < 1000 && irqCount == n; cyc++) @(posedge ref_clk);
      chk(cyc >= IDLE - 2 && cyc <= IDLE + 20, 1);
      rd(ST, d);
      chk(d[0], 1);
   endtask
   task give_verdict();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      give_verdict();
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      rd(ST, d);
      chk(d & 8'hCF, 8'h00);
      rd(MD, d);
      chk(d, 8'h00);
      rd(CK, d);
      chk(d, 8'h00);
      rd(8'h55, d);
      chk(d, 8'h00);
      wr(MD, 8'h10);
      repeat (8) @(posedge ref_clk);
      rd(ST, d);
      chk(d[5:4], 2'h3);
      for (int i = 0; i < 24; i++) begin
         v = (i < 16) ? 4'(i) : 4'(rnd());
         wr(ST, {v[3:2], 6'h00});
         clkLow <= v[1];
         datLow <= v[0];
         repeat (8) @(posedge ref_clk);
         rd(ST, d);
         chk(d[5:4], aux_exp(v));
         chk({clkLevel, datLevel}, aux_exp(v));
      end
      clkLow <= 1'b0;
      datLow <= 1'b0;
      wr(MD, 8'h30);
      usbMode <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk({link.devDpOeN, link.devDmOeN}, 2'h3);
      go(3'h1);
      repeat (IDLE + 60) @(posedge ref_clk);
      rd(ST, d);
      chk(8'(irqCount), 0);
      chk(d[0], 0);
      go(3'h2);
      repeat (2) @(posedge ref_clk);
      chk(busy, 1);
      host_idle();
      wr(MD, 8'h20);
      // short random drive only: a long K would read as a wake
      for (int i = 0; i < 5; i++) begin
         r = rnd();
         sieDrive <= 1'b1;
         sieDp <= r[0];
         sieDm <= r[1];
         repeat (3) @(posedge ref_clk);
         chk({link.devDpOeN, link.devDmOeN, link.devDpOut, link.devDmOut}, {2'h0, r[0], r[1]});
      end
      sieDrive <= 1'b0;
      w = wakeCount;
      wr(ST, 8'hC2);
      repeat (100) @(posedge ref_clk);
      chk(8'(wakeCount - w), 0);
      go(3'h4);
      host_idle();
      rd(ST, d);
      chk(d[2], 1);
      wr(ST, 8'hC0);
      rd(ST, d);
      chk(d[2], 0);
      suspend_timed();
      wr(CK, 8'h00);
      rd(CK, d);
      chk(d, 8'h00);
      n = irqCount;
      go(3'h2);
      wait_irq(n + 1);
      rd(ST, d);
      chk({d[3], d[0]}, 2'h3);
      v = 4'h0;
      for (int k = 0; k < 300 && d[0] === 1'b1; k++) begin
         rd(ST, d);
         if (d[3] === 1'b0 && d[0] === 1'b1) v = 4'h1;
      end
      chk(v, 1);
      wait_irq(n + 2);
      chk(8'(irqCount - n), 2);
      wr(CK, 8'h08);
      rd(CK, d);
      chk(d, 8'h08);
      host_idle();
      suspend_timed();
      n = irqCount;
      w = wakeCount;
      wr(ST, 8'hC2);
      wait_irq(n + 2);
      chk(8'(wakeCount - w), 1);
      rd(ST, d);
      chk(d[0], 0);
      for (int i = 0; i < 4; i++) begin
         wr(CK, {3'h0, i[0], 4'h8});
         lvr <= i[1];
         repeat (3) @(posedge ref_clk);
         chk({engClk, deepSusp, resetReq}, {1'b1, i[0], i[0] & i[1]});
      end
      rd(CK, d);
      chk(d, 8'h18);
      give_verdict();
   end
endmodule
`default_nettype wire
